// ===== rtl/fees_pkg.sv
// package: constants for the flash erase error status block
package fees_pkg;
    localparam logic [7:0] FEES_SEL_BOOT_ARRAY  = 8'hAA;
    localparam int         FEES_BIT_ERASE_ERR   = 5;
    localparam int         FEES_BIT_KEY_ERR     = 4;
    localparam logic       FEES_RST_ERASE_ERR   = 1'b0;
    localparam logic       FEES_RST_KEY_ERR     = 1'b0;
    localparam logic [7:0] FEES_KEY_ERASE_OK    = 8'h5A;
    localparam int         FEES_ERASE_CYCLES    = 16;
    localparam int         FEES_CNT_W           = 16;

    typedef enum logic [1:0] {
        FEES_IDLE,
        FEES_ERASE,
        FEES_DONE
    } fees_state_type;
endpackage

// ===== rtl/fees_timer.sv
// erase duration timer: counts down from load, pulses when done
module fees_timer
    import fees_pkg::*;
#(
    parameter int CNT_W = FEES_CNT_W
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_value,
    output logic                  busy,
    output logic                  expired
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_busy;
    logic             next_expired;

    always_comb begin
        next_count   = count;
        next_busy    = busy;
        next_expired = 1'b0;
        if (load) begin
            next_count = load_value;
            next_busy  = 1'b1;
        end else if (busy) begin
            if (count <= CNT_W'(1)) begin
                next_busy    = 1'b0;
                next_expired = 1'b1;
                next_count   = '0;
            end else begin
                next_count = count - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            busy    <= 1'b0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            busy    <= next_busy;
            expired <= next_expired;
        end
    end
endmodule

// ===== rtl/fees_top.sv
// top: erase sequencer error reporting (erase and key-check flags)
module fees_top
    import fees_pkg::*;
#(
    parameter int         ERASE_CYCLES = FEES_ERASE_CYCLES,
    parameter int         CNT_W        = FEES_CNT_W,
    parameter logic [7:0] KEY_OK       = FEES_KEY_ERASE_OK
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       erase_start,
    input  wire logic [7:0] memory_array_select_register,
    input  wire logic [7:0] flash_key_register,
    input  wire logic       erase_fail,
    input  wire logic       branch_return,
    input  wire logic       reg_changed,
    input  wire logic       flag_wr,
    input  wire logic       flag_wr_erase,
    input  wire logic       flag_wr_key,
    output logic            erase_error_flag,
    output logic            key_check_error_flag,
    output logic            erase_busy,
    output logic            erase_done,
    output logic            erase_array_en
);
    // sequencer state
    fees_state_type state;
    fees_state_type next_state;
    logic           next_erase_busy;
    logic           next_erase_array_en;
    logic           next_erase_done;

    // failure latch
    logic           fail_seen;
    logic           next_fail_seen;

    // status flags
    logic           next_erase_error_flag;
    logic           next_key_check_error_flag;

    // request decode
    logic           start_taken;
    logic           sel_boot;
    logic           key_bad;
    logic           start_reject;
    logic           start_accept;
    logic           fail_event;
    logic           sw_write;

    // erase timer
    logic           tmr_load;
    logic           tmr_expired;

    fees_timer #(
        .CNT_W      (CNT_W)
    ) u_timer (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .load       (tmr_load),
        .load_value (CNT_W'(ERASE_CYCLES)),
        .busy       (),
        .expired    (tmr_expired)
    );

    // requests are decoded once so that every group sees the same verdict
    always_comb begin
        start_taken  = erase_start && (state == FEES_IDLE);
        sel_boot     = (memory_array_select_register == FEES_SEL_BOOT_ARRAY);
        key_bad      = (flash_key_register != KEY_OK);
        start_reject = start_taken && (sel_boot || key_bad);
        start_accept = start_taken && !sel_boot && !key_bad;
        // software writes only outside a sequence, so status stays coherent
        sw_write     = flag_wr && (state == FEES_IDLE);
        tmr_load     = start_accept;
        fail_event   = 1'b0;
        if (erase_fail) begin
            fail_event = 1'b1;
        end
        if (branch_return && reg_changed) begin
            fail_event = 1'b1;
        end
    end

    always_comb begin
        next_state          = state;
        next_erase_busy     = erase_busy;
        next_erase_array_en = erase_array_en;
        next_erase_done     = 1'b0;
        case (state)
            FEES_IDLE: begin
                if (start_accept) begin
                    next_state          = FEES_ERASE;
                    next_erase_busy     = 1'b1;
                    next_erase_array_en = 1'b1;
                end else if (start_reject) begin
                    // rejected request ends at once, the array is never driven
                    next_erase_array_en = 1'b0;
                    next_erase_done     = 1'b1;
                end
            end
            FEES_ERASE: begin
                if (tmr_expired) begin
                    next_state = FEES_DONE;
                end
            end
            FEES_DONE: begin
                next_state          = FEES_IDLE;
                next_erase_busy     = 1'b0;
                next_erase_array_en = 1'b0;
                next_erase_done     = 1'b1;
            end
            default: begin
                next_state          = FEES_IDLE;
                next_erase_busy     = 1'b0;
                next_erase_array_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state          <= FEES_IDLE;
            erase_busy     <= 1'b0;
            erase_array_en <= 1'b0;
            erase_done     <= 1'b0;
        end else begin
            state          <= next_state;
            erase_busy     <= next_erase_busy;
            erase_array_en <= next_erase_array_en;
            erase_done     <= next_erase_done;
        end
    end

    // sticky for the whole sequence; cleared only when a new one starts
    always_comb begin
        next_fail_seen = fail_seen;
        if (start_accept) begin
            next_fail_seen = 1'b0;
        end else if ((state != FEES_IDLE) && fail_event) begin
            next_fail_seen = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fail_seen <= 1'b0;
        end else begin
            fail_seen <= next_fail_seen;
        end
    end

    // a new request wins over a software write in the same cycle
    always_comb begin
        next_erase_error_flag     = erase_error_flag;
        next_key_check_error_flag = key_check_error_flag;
        if (sw_write) begin
            next_erase_error_flag     = flag_wr_erase;
            next_key_check_error_flag = flag_wr_key;
        end
        if (start_taken) begin
            next_key_check_error_flag = key_bad;
        end
        if (start_reject && sel_boot) begin
            next_erase_error_flag = 1'b1;
        end else if (start_reject) begin
            next_erase_error_flag = 1'b1;
        end else if (start_accept) begin
            next_erase_error_flag = 1'b0;
        end else if (state == FEES_DONE) begin
            // a failure in the closing cycle still counts
            next_erase_error_flag = fail_seen || fail_event;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            erase_error_flag     <= FEES_RST_ERASE_ERR;
            key_check_error_flag <= FEES_RST_KEY_ERR;
        end else begin
            erase_error_flag     <= next_erase_error_flag;
            key_check_error_flag <= next_key_check_error_flag;
        end
    end
endmodule

// ===== tb/fees_top_sva.sv
// checker: assertions on the erase error status ports
module fees_top_chk
    import fees_pkg::*;
#(
    parameter logic [7:0] KEY_OK = FEES_KEY_ERASE_OK
) (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       erase_start,
    input wire logic [7:0] memory_array_select_register,
    input wire logic [7:0] flash_key_register,
    input wire logic       erase_fail,
    input wire logic       branch_return,
    input wire logic       reg_changed,
    input wire logic       flag_wr,
    input wire logic       erase_error_flag,
    input wire logic       key_check_error_flag,
    input wire logic       erase_busy,
    input wire logic       erase_done,
    input wire logic       erase_array_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic go;
    logic bad_key;
    logic bad;
    assign go = erase_start && !erase_busy;
    assign bad_key = flash_key_register != KEY_OK;
    assign bad = bad_key
        || memory_array_select_register == FEES_SEL_BOOT_ARRAY;
    property p_fail;
        erase_busy && erase_fail |-> ##[1:40] erase_done && erase_error_flag;
    endproperty
    a_fail: assert property (p_fail) else $error("failure lost");
    property p_br;
        erase_busy && branch_return && reg_changed
            |-> ##[1:40] erase_done && erase_error_flag;
    endproperty
    a_br: assert property (p_br) else $error("branch change lost");
    property p_rej;
        go && bad |=> erase_done && erase_error_flag;
    endproperty
    a_rej: assert property (p_rej) else $error("reject not flagged");
    property p_none;
        go && bad |=> !erase_array_en [*2];
    endproperty
    a_none: assert property (p_none) else $error("array erased");
    property p_ok;
        go && !bad |=> erase_busy && !erase_error_flag
            && !key_check_error_flag;
    endproperty
    a_ok: assert property (p_ok) else $error("flags not clear");
    property p_key;
        go && bad_key |=> key_check_error_flag;
    endproperty
    a_key: assert property (p_key) else $error("key error lost");
    property p_hold;
        !erase_busy && !erase_start && !flag_wr |=> $stable(erase_error_flag)
            && $stable(key_check_error_flag);
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed");
endmodule

bind fees_top fees_top_chk #(.KEY_OK(KEY_OK)) i_chk (.*);

// ===== tb/fees_top_tb_top.sv
// testbench: erase outcomes, key check and flag hold
module fees_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fees_pkg::*;
    localparam int ERASE_N = 4;
    logic clk_sys = 0, rst_n = 0, erase_start = 0, erase_fail = 0;
    logic branch_return = 0, reg_changed = 0, flag_wr = 0;
    logic flag_wr_erase = 0, flag_wr_key = 0;
    logic [7:0] memory_array_select_register = 8'h00;
    logic [7:0] flash_key_register = 8'h00;
    logic erase_error_flag, key_check_error_flag;
    logic erase_busy, erase_done, erase_array_en;
    int err_count = 0, check_count = 0;
    fees_top #(.ERASE_CYCLES(ERASE_N)) i_dut (.*);
    always #5 clk_sys = ~clk_sys;
    task automatic check(logic [15:0] v, logic [15:0] e, string n);
        check_count++;
        if (v !== e) begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, v);
        end
    endtask
    task automatic erase(logic [7:0] s, k, logic f, b, c, ee, fk);
        logic en;
        logic acc;
        int   n;
        en = 0;
        n = 0;
        acc = s != FEES_SEL_BOOT_ARRAY && k == FEES_KEY_ERASE_OK;
        @(negedge clk_sys);
        memory_array_select_register = s;
        flash_key_register = k;
        erase_start = 1;
        @(negedge clk_sys);
        erase_start = 0;
        check(erase_busy, acc, "erase_busy");
        {erase_fail, branch_return, reg_changed} = {f, b, c};
        while (n < 20 && erase_done !== 1'b1) begin
            en |= erase_array_en;
            n++;
            @(negedge clk_sys);
            {erase_fail, branch_return, reg_changed} = 3'h0;
        end
        check(erase_done, 1, "erase_done");
        check(16'(n), acc ? 16'(ERASE_N + 2) : 16'h0000, "cycles");
        check(erase_busy, 0, "erase_busy end");
        check(erase_error_flag, ee, "erase_error_flag");
        check(key_check_error_flag, fk, "key_check_error_flag");
        check(en, acc, "erase_array_en");
        @(negedge clk_sys);
        {erase_fail, branch_return, reg_changed} = 3'h0;
        check(erase_done, 0, "erase_done pulse");
    endtask
    task automatic wr(logic e, k);
        @(negedge clk_sys);
        flag_wr = 1;
        {flag_wr_erase, flag_wr_key} = {e, k};
        @(negedge clk_sys);
        flag_wr = 0;
        check(erase_error_flag, e, "written ee");
        check(key_check_error_flag, k, "written fk");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1;
        check(erase_error_flag, 0, "reset ee");
        check(key_check_error_flag, 0, "reset fk");
        // user program mode: boot array is never expected erased
        erase(8'h00, 8'h5A, 1, 0, 0, 1, 0);
        erase(8'h00, 8'h5A, 0, 0, 0, 0, 0);
        erase(8'h00, 8'h5A, 0, 1, 1, 1, 0);
        erase(8'h00, 8'h5A, 0, 1, 0, 0, 0);
        erase(8'hAA, 8'h5A, 0, 0, 0, 1, 0);
        erase(8'h00, 8'h5A, 0, 0, 0, 0, 0);
        erase(8'h00, 8'h5B, 0, 0, 0, 1, 1);
        repeat (6) @(negedge clk_sys);
        check(erase_error_flag, 1, "held ee");
        check(key_check_error_flag, 1, "held fk");
        wr(0, 1);
        wr(1, 0);
        tally_and_finish;
    end
endmodule
